// file: hw/scp_fifo.sv
// write-word fifo between serial side and register buffer
module scp_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  // system
  input wire logic mclk,
  input wire logic srst,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wr_ptr_r;
  logic [PW:0] rd_ptr_r;
  logic full;
  logic empty;

  assign empty = (wr_ptr_r == rd_ptr_r);
  assign full = (wr_ptr_r[PW-1:0] == rd_ptr_r[PW-1:0]) &&
                (wr_ptr_r[PW] != rd_ptr_r[PW]);
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = mem[rd_ptr_r[PW-1:0]];

  always_ff @(posedge mclk) begin
    if (in_valid && !full) begin
      mem[wr_ptr_r[PW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      wr_ptr_r <= '0;
    end else if (in_valid && !full) begin
      wr_ptr_r <= wr_ptr_r + 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rd_ptr_r <= '0;
    end else if (out_ready && !empty) begin
      rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end
endmodule : scp_fifo

// file: hw/scp_slave.sv
// serial control port slave with shadow buffer and active registers
module scp_slave #(
  parameter int NUM_REGS = scp_pkg::SCP_NUM_REGS,
  parameter int FIFO_DEPTH = scp_pkg::SCP_FIFO_DEPTH
) (
  // system
  input wire logic mclk,
  input wire logic srst,
  // serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe,
  output logic readback_out_pin,
  output logic readback_out_pin_oe,
  // active register read port
  input wire logic [scp_pkg::SCP_ADDR_W-1:0] active_rd_addr,
  output logic [scp_pkg::SCP_BYTE_W-1:0] active_rd_data,
  // status
  output logic reg_busy
);
  import scp_pkg::*;

  // register storage
  logic [7:0] shadow_mem [NUM_REGS];
  logic [7:0] active_mem [NUM_REGS];

  // synchronised link levels and edges
  logic [SCP_SYNC_W-1:0] lvl;
  logic cs_lvl, sclk_lvl, sdi_lvl;
  logic sclk_prev_r, cs_prev_r;
  logic sclk_rise, cs_rise, cs_fall;

  // serial engine state
  scp_state_e state_r;
  logic phase_r, rw_r;
  logic [3:0] cnt_r;
  logic [15:0] sh_r, sh_nxt;
  logic [1:0] len_r, left_r;
  logic [9:0] addr_r, addr_step;
  logic [7:0] tx_r, cfg_r, rx_byte;
  logic lsb_first, stream, instr_done, byte_done;
  logic last_byte, at_boundary, drive_en;

  // write path
  logic pend_r, fifo_in_ready, fifo_out_valid, take;
  logic [SCP_FIFO_W-1:0] pend_word_r, fifo_out_data;
  logic [9:0] drain_addr;
  logic [7:0] drain_data;

  // register side sequencer
  logic busy_r, init_r, rb_active_r;
  logic [9:0] bcnt_r;

  function automatic logic [15:0] scp_shift(input logic [15:0] sh,
                                            input logic b,
                                            input logic lsb);
    scp_shift = lsb ? {b, sh[15:1]} : {sh[14:0], b};
  endfunction : scp_shift

  function automatic logic [9:0] scp_step(input logic [9:0] a,
                                          input logic lsb);
    if (lsb) begin
      scp_step = a + SCP_ADDR_ONE;
    end else if (a == SCP_ADDR_ZERO) begin
      scp_step = SCP_LAST_ADDR;
    end else begin
      scp_step = a - SCP_ADDR_ONE;
    end
  endfunction : scp_step

  function automatic logic [7:0] scp_rd_byte(input logic [9:0] a);
    if (a == SCP_CFG_ADDR) begin
      scp_rd_byte = cfg_r;
    end else if (a > SCP_LAST_ADDR) begin
      scp_rd_byte = SCP_BYTE_ZERO;
    end else if (rb_active_r) begin
      scp_rd_byte = active_mem[a];
    end else begin
      scp_rd_byte = shadow_mem[a];
    end
  endfunction : scp_rd_byte

  scp_sync #(
    .WIDTH(SCP_SYNC_W),
    .RESET_VAL(SCP_SYNC_RESET)
  ) u_sync (
    .mclk(mclk),
    .srst(srst),
    .din({cs_n, sclk, sdio_i}),
    .dout(lvl)
  );

  assign cs_lvl = lvl[2];
  assign sclk_lvl = lvl[1];
  assign sdi_lvl = lvl[0];

  always_ff @(posedge mclk) begin
    if (srst) begin
      sclk_prev_r <= 1'b0;
      cs_prev_r <= 1'b1;
    end else begin
      sclk_prev_r <= sclk_lvl;
      cs_prev_r <= cs_lvl;
    end
  end

  assign sclk_rise = sclk_lvl & ~sclk_prev_r;
  assign cs_rise = cs_lvl & ~cs_prev_r;
  assign cs_fall = ~cs_lvl & cs_prev_r;

  // decode of the current step
  assign lsb_first = cfg_r[SCP_CFG_LSB_BIT];
  assign stream = (len_r == SCP_LEN_STREAM);
  assign sh_nxt = scp_shift(sh_r, sdi_lvl, lsb_first);
  assign rx_byte = lsb_first ? sh_nxt[15:8] : sh_nxt[7:0];
  assign addr_step = scp_step(addr_r, lsb_first);
  assign instr_done = (state_r == SCP_ST_SHIFT) && !phase_r && sclk_rise &&
                      !cs_rise && (cnt_r == SCP_CNT_INSTR_LAST);
  assign byte_done = (state_r == SCP_ST_SHIFT) && phase_r && sclk_rise &&
                     !cs_rise && (cnt_r == SCP_CNT_BYTE_LAST);
  assign last_byte = stream ? (addr_r == SCP_LAST_ADDR)
                            : (left_r == SCP_LEFT_NONE);
  assign at_boundary = (cnt_r == (phase_r ? SCP_CNT_ZERO : SCP_CNT_HALF));

  // transaction sequencing
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_r <= SCP_ST_IDLE;
      phase_r <= 1'b0;
      cnt_r <= SCP_CNT_ZERO;
    end else begin
      case (state_r)
        SCP_ST_IDLE: begin
          if (cs_fall) begin
            state_r <= SCP_ST_SHIFT;
            phase_r <= 1'b0;
            cnt_r <= SCP_CNT_ZERO;
          end
        end
        SCP_ST_SHIFT: begin
          if (cs_rise) begin
            if (!phase_r && cnt_r == SCP_CNT_ZERO) begin
              state_r <= SCP_ST_IDLE;
            end else if (at_boundary && !(phase_r && stream)) begin
              state_r <= SCP_ST_STALL;
            end else begin
              state_r <= SCP_ST_IDLE;
              cnt_r <= SCP_CNT_ZERO;
            end
          end else if (instr_done) begin
            phase_r <= 1'b1;
            cnt_r <= SCP_CNT_ZERO;
          end else if (byte_done) begin
            cnt_r <= SCP_CNT_ZERO;
            if (last_byte) begin
              state_r <= SCP_ST_DONE;
            end
          end else if (sclk_rise) begin
            cnt_r <= cnt_r + SCP_CNT_ONE;
          end
        end
        SCP_ST_STALL: begin
          if (cs_fall) begin
            state_r <= SCP_ST_SHIFT;
          end
        end
        SCP_ST_DONE: begin
          if (cs_rise) begin
            state_r <= SCP_ST_IDLE;
          end
        end
        default: begin
          state_r <= SCP_ST_IDLE;
        end
      endcase
    end
  end

  // instruction and data shifting
  always_ff @(posedge mclk) begin
    if (srst) begin
      sh_r <= '0;
    end else if (state_r == SCP_ST_SHIFT && sclk_rise && !cs_rise) begin
      sh_r <= sh_nxt;
    end
  end

  // instruction decode and address stepping
  always_ff @(posedge mclk) begin
    if (srst) begin
      rw_r <= 1'b0;
      len_r <= SCP_LEFT_NONE;
      left_r <= SCP_LEFT_NONE;
      addr_r <= SCP_ADDR_ZERO;
    end else if (instr_done) begin
      rw_r <= sh_nxt[SCP_RW_BIT];
      len_r <= sh_nxt[SCP_LEN_HI:SCP_LEN_LO];
      left_r <= sh_nxt[SCP_LEN_HI:SCP_LEN_LO];
      addr_r <= sh_nxt[SCP_ADDR_HI:0];
    end else if (byte_done && !last_byte) begin
      addr_r <= addr_step;
      if (!stream) begin
        left_r <= left_r - SCP_LEFT_ONE;
      end
    end
  end

  // port configuration, effective without update
  always_ff @(posedge mclk) begin
    if (srst) begin
      cfg_r <= SCP_CFG_RESET;
    end else if (byte_done && !rw_r && addr_r == SCP_CFG_ADDR) begin
      cfg_r <= rx_byte;
    end
  end

  // readback shifter, bit advances on rising edges
  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_r <= SCP_BYTE_ZERO;
    end else if (instr_done) begin
      tx_r <= scp_rd_byte(sh_nxt[SCP_ADDR_HI:0]);
    end else if (byte_done && rw_r) begin
      tx_r <= scp_rd_byte(addr_step);
    end else if (state_r == SCP_ST_SHIFT && phase_r && rw_r &&
                 sclk_rise && !cs_rise) begin
      tx_r <= lsb_first ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
    end
  end

  // pin drivers
  assign drive_en = (state_r == SCP_ST_SHIFT) && phase_r && rw_r && !cs_lvl;

  always_ff @(posedge mclk) begin
    if (srst) begin
      sdio_o <= 1'b0;
      readback_out_pin <= 1'b0;
      sdio_oe <= 1'b0;
      readback_out_pin_oe <= 1'b0;
    end else begin
      sdio_o <= lsb_first ? tx_r[0] : tx_r[7];
      readback_out_pin <= lsb_first ? tx_r[0] : tx_r[7];
      sdio_oe <= drive_en && !cfg_r[SCP_CFG_SDO_BIT];
      readback_out_pin_oe <= drive_en && cfg_r[SCP_CFG_SDO_BIT];
    end
  end

  // completed write bytes, except those to serial_port_config, wait here for the fifo
  always_ff @(posedge mclk) begin
    if (srst) begin
      pend_r <= 1'b0;
      pend_word_r <= '0;
    end else if (byte_done && !rw_r && addr_r != SCP_CFG_ADDR) begin
      pend_r <= 1'b1;
      pend_word_r <= {addr_r, rx_byte};
    end else if (fifo_in_ready) begin
      pend_r <= 1'b0;
    end
  end

  scp_fifo #(
    .WIDTH(SCP_FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .srst(srst),
    .in_valid(pend_r),
    .in_data(pend_word_r),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(!busy_r)
  );

  assign drain_addr = fifo_out_data[SCP_FIFO_W-1:SCP_BYTE_W];
  assign drain_data = fifo_out_data[SCP_BYTE_W-1:0];
  assign take = fifo_out_valid && !busy_r;

  // clear after reset, then copy on each update
  always_ff @(posedge mclk) begin
    if (srst) begin
      busy_r <= 1'b1;
      init_r <= 1'b1;
      bcnt_r <= SCP_ADDR_ZERO;
    end else if (busy_r) begin
      bcnt_r <= bcnt_r + SCP_ADDR_ONE;
      if (bcnt_r == SCP_LAST_ADDR) begin
        busy_r <= 1'b0;
        init_r <= 1'b0;
      end
    end else if (take && drain_addr == SCP_UPDATE_ADDR &&
                 drain_data[SCP_UPDATE_BIT]) begin
      busy_r <= 1'b1;
      init_r <= 1'b0;
      bcnt_r <= SCP_ADDR_ZERO;
    end
  end

  always_ff @(posedge mclk) begin
    if (busy_r && init_r) begin
      shadow_mem[bcnt_r] <= SCP_BYTE_ZERO;
    end else if (take && drain_addr <= SCP_LAST_ADDR) begin
      if (drain_addr == SCP_UPDATE_ADDR) begin
        shadow_mem[drain_addr] <= drain_data & ~SCP_UPDATE_MASK;
      end else begin
        shadow_mem[drain_addr] <= drain_data;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (busy_r) begin
      active_mem[bcnt_r] <= init_r ? SCP_BYTE_ZERO : shadow_mem[bcnt_r];
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      rb_active_r <= 1'b0;
    end else if (busy_r && !init_r && bcnt_r == SCP_RB_SEL_ADDR) begin
      rb_active_r <= shadow_mem[bcnt_r][SCP_RB_SEL_BIT];
    end
  end

  // read port and status
  always_ff @(posedge mclk) begin
    if (srst) begin
      active_rd_data <= SCP_BYTE_ZERO;
      reg_busy <= 1'b1;
    end else begin
      reg_busy <= busy_r;
      if (active_rd_addr <= SCP_LAST_ADDR) begin
        active_rd_data <= active_mem[active_rd_addr];
      end else begin
        active_rd_data <= SCP_BYTE_ZERO;
      end
    end
  end
endmodule : scp_slave

// file: hw/scp_sync.sv
// three-stage pin synchroniser with agreement filter
module scp_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // system
  input wire logic mclk,
  input wire logic srst,
  // pins and filtered levels
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge mclk) begin
        if (srst) begin
          s1_r[i] <= RESET_VAL[i];
          s2_r[i] <= RESET_VAL[i];
          s3_r[i] <= RESET_VAL[i];
          dout[i] <= RESET_VAL[i];
        end else begin
          s1_r[i] <= din[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          if (s2_r[i] == s3_r[i]) begin
            dout[i] <= s3_r[i];
          end
        end
      end
    end
  endgenerate
endmodule : scp_sync

// file: shared/scp_pkg.sv
// constants, field layout and state encoding of the serial control port
package scp_pkg;
  localparam int SCP_ADDR_W = 10;
  localparam int SCP_INSTR_W = 16;
  localparam int SCP_BYTE_W = 8;
  localparam int SCP_NUM_REGS = 563;
  localparam int SCP_FIFO_DEPTH = 8;
  localparam int SCP_FIFO_W = SCP_ADDR_W + SCP_BYTE_W;
  localparam int SCP_SYNC_W = 3;
  // register addresses
  localparam logic [9:0] SCP_CFG_ADDR = 10'h000;
  localparam logic [9:0] SCP_RB_SEL_ADDR = 10'h004;
  localparam logic [9:0] SCP_UPDATE_ADDR = 10'h232;
  localparam logic [9:0] SCP_LAST_ADDR = 10'h232;
  localparam logic [9:0] SCP_ADDR_ONE = 10'h001;
  localparam logic [9:0] SCP_ADDR_ZERO = 10'h000;
  // serial_port_config fields, update and readback select bits
  localparam logic [7:0] SCP_CFG_RESET = 8'h18;
  localparam int SCP_CFG_SDO_BIT = 0;
  localparam int SCP_CFG_LSB_BIT = 1;
  localparam int SCP_UPDATE_BIT = 0;
  localparam int SCP_RB_SEL_BIT = 0;
  localparam logic [7:0] SCP_UPDATE_MASK = 8'h01;
  localparam logic [7:0] SCP_BYTE_ZERO = 8'h00;
  // instruction word fields
  localparam int SCP_RW_BIT = 15;
  localparam int SCP_LEN_HI = 14;
  localparam int SCP_LEN_LO = 13;
  localparam int SCP_ADDR_HI = 9;
  localparam logic [1:0] SCP_LEN_STREAM = 2'h3;
  localparam logic [1:0] SCP_LEFT_ONE = 2'h1;
  localparam logic [1:0] SCP_LEFT_NONE = 2'h0;
  // bit counters
  localparam logic [3:0] SCP_CNT_ZERO = 4'h0;
  localparam logic [3:0] SCP_CNT_ONE = 4'h1;
  localparam logic [3:0] SCP_CNT_HALF = 4'h8;
  localparam logic [3:0] SCP_CNT_BYTE_LAST = 4'h7;
  localparam logic [3:0] SCP_CNT_INSTR_LAST = 4'hf;
  // synchroniser reset level: {cs_n, sclk, sdio}
  localparam logic [2:0] SCP_SYNC_RESET = 3'h4;

  typedef enum logic [1:0] {
    SCP_ST_IDLE  = 2'b00,
    SCP_ST_SHIFT = 2'b01,
    SCP_ST_STALL = 2'b10,
    SCP_ST_DONE  = 2'b11
  } scp_state_e;
endpackage : scp_pkg

// file: tb/scp_ctrl_model.sv
// serial controller model driving the link
module scp_ctrl_model (
  // system
  input wire logic mclk,
  // link
  output logic sclk,
  output logic cs_n,
  output logic m_val,
  output logic m_en,
  input wire logic sdio_w,
  input wire logic sdo_w
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lsb = 1'b0;
  logic sep = 1'b0;
  logic [7:0] wb [8];
  logic [7:0] rb [8];
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    m_val = 1'b0;
    m_en = 1'b0;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  // one field, bit order from lsb
  task automatic field(input logic [15:0] w, input int n, input logic en,
                       output logic [15:0] r);
    int k;
    r = '0;
    for (int i = 0; i < n; i++) begin
      k = lsb ? i : n - 1 - i;
      m_val <= w[k];
      m_en <= en;
      cyc(6);
      sclk <= 1'b1;
      cyc(2);
      r[k] = sep ? sdo_w : sdio_w;
      sclk <= 1'b0;
    end
  endtask : field
  task automatic xfer(input logic rw, input logic [1:0] len,
                      input logic [9:0] a, input int nb, input int cut,
                      input logic stall);
    logic [15:0] r;
    cs_n <= 1'b0;
    field({rw, len, 3'h0, a}, 16, 1'b1, r);
    for (int b = 0; b < nb; b++) begin
      if (stall && b > 0) begin
        cs_n <= 1'b1;
        cyc(20);
        cs_n <= 1'b0;
      end
      field({8'h00, wb[b]}, (b == nb - 1 && cut > 0) ? cut : 8, !rw, r);
      rb[b] = r[7:0];
    end
    cyc(2);
    cs_n <= 1'b1;
    m_en <= 1'b0;
    cyc(16);
  endtask : xfer
endmodule : scp_ctrl_model

// file: tb/scp_slave_chk.sv
// assertions on the serial control port slave pins
module scp_slave_chk
  import scp_pkg::*;
#(
  parameter int NUM_REGS = SCP_NUM_REGS
) (
  // system
  input wire logic mclk,
  input wire logic srst,
  // serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdio_o,
  input wire logic sdio_oe,
  input wire logic readback_out_pin,
  input wire logic readback_out_pin_oe,
  // active register read port
  input wire logic [scp_pkg::SCP_ADDR_W-1:0] active_rd_addr,
  input wire logic [scp_pkg::SCP_BYTE_W-1:0] active_rd_data,
  // status
  input wire logic reg_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  int busy_cnt;
  int low_run;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // length of the current busy run
  always_ff @(posedge mclk) begin
    if (srst || !reg_busy) busy_cnt <= 0;
    else busy_cnt <= busy_cnt + 1;
  end
  // samples since serial clock was last high
  always_ff @(posedge mclk) begin
    if (srst || sclk) low_run <= 0;
    else if (low_run < 15) low_run <= low_run + 1;
  end
  sequence sel_idle_s;
    cs_n [*8] ##1 cs_n [*4];
  endsequence
  sequence oe_start_s;
    $rose(sdio_oe) or $rose(readback_out_pin_oe);
  endsequence
  chk_idle_no_drive: assert property (
    sel_idle_s |-> !sdio_oe && !readback_out_pin_oe)
    else $error("data pin driven while deselected");
  chk_one_driver: assert property (
    !(sdio_oe && readback_out_pin_oe))
    else $error("both data pins driven");
  chk_pins_agree: assert property (
    readback_out_pin_oe |-> readback_out_pin == sdio_o)
    else $error("separate pin differs from shared bit");
  chk_drive_needs_sel: assert property (
    oe_start_s |-> !cs_n)
    else $error("drive started without select");
  chk_bit_steady: assert property (
    sdio_oe && $past(sdio_oe) && $changed(sdio_o) |-> low_run < 12)
    else $error("readback bit moved without clock");
  chk_busy_at_start: assert property (
    $fell(srst) |-> reg_busy)
    else $error("busy low after reset");
  chk_busy_len: assert property (
    reg_busy |-> busy_cnt <= NUM_REGS + 2)
    else $error("busy run too long");
  chk_busy_full: assert property (
    $fell(reg_busy) |-> busy_cnt >= NUM_REGS - 1)
    else $error("busy run too short");
  chk_rd_beyond_map: assert property (
    $past(active_rd_addr) > SCP_LAST_ADDR |-> active_rd_data == 8'h00)
    else $error("unmapped active read not zero");
endmodule : scp_slave_chk

// file: tb/test_serial_control_port_slave.sv
// testbench of the serial control port slave
module test_serial_control_port_slave;
  timeunit 1ns;
  timeprecision 1ps;
  import scp_pkg::*;
  logic mclk, srst, sclk, cs_n, m_val, m_en, sdio_last;
  logic sdio_o, sdio_oe, rb_pin, rb_oe, reg_busy;
  logic [SCP_ADDR_W-1:0] rd_addr;
  logic [SCP_BYTE_W-1:0] rd_data;
  logic [7:0] shadow [1024];
  logic [7:0] act [1024];
  wire logic sdio_w, sdo_w;
  int error_cnt = 0;
  int total_checks = 0;
  int seed = 60;
  int cycles = 0;
  // undriven lines show the inverse of the last level
  assign sdio_w = sdio_oe ? sdio_o : (m_en ? m_val : ~sdio_last);
  assign sdo_w = rb_oe ? rb_pin : ~sdio_last;
  scp_slave #(.NUM_REGS(SCP_NUM_REGS), .FIFO_DEPTH(SCP_FIFO_DEPTH)) uut (
    .mclk(mclk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .sdio_i(sdio_w),
    .sdio_o(sdio_o), .sdio_oe(sdio_oe), .readback_out_pin(rb_pin),
    .readback_out_pin_oe(rb_oe), .active_rd_addr(rd_addr),
    .active_rd_data(rd_data), .reg_busy(reg_busy));
  scp_ctrl_model mdl (.mclk(mclk), .sclk(sclk), .cs_n(cs_n), .m_val(m_val),
    .m_en(m_en), .sdio_w(sdio_w), .sdo_w(sdo_w));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) sdio_last <= sdio_w;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run
  task automatic check(input string what, input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [9:0] nxt(input logic [9:0] p);
    if (mdl.lsb) return p + 10'h001;
    return p == 10'h000 ? SCP_LAST_ADDR : p - 10'h001;
  endfunction : nxt
  function automatic logic [7:0] rb_exp(input logic [9:0] p);
    if (p != SCP_CFG_ADDR && act[SCP_RB_SEL_ADDR][SCP_RB_SEL_BIT]) begin
      return act[p];
    end
    return shadow[p];
  endfunction : rb_exp
  task automatic settle();
    int n;
    n = 0;
    while (reg_busy !== 1'b0 && n < 2000) begin
      @(posedge mclk);
      n++;
    end
    check("busy", {7'h00, reg_busy}, 8'h00);
  endtask : settle
  task automatic wr(input logic [1:0] len, input logic [9:0] a, input int nb,
                    input int cut, input logic stall, input logic fix);
    logic [9:0] p;
    p = a;
    for (int b = 0; b < nb; b++) begin
      if (!fix) mdl.wb[b] = 8'($random(seed));
      if (cut == 0 || b < nb - 1) begin
        shadow[p] = p == SCP_LAST_ADDR ? mdl.wb[b] & ~SCP_UPDATE_MASK
                                       : mdl.wb[b];
      end
      p = nxt(p);
    end
    mdl.xfer(1'b0, len, a, nb, cut, stall);
  endtask : wr
  task automatic rd(input logic [1:0] len, input logic [9:0] a, input int nb);
    logic [9:0] p;
    p = a;
    mdl.xfer(1'b1, len, a, nb, 0, 1'b0);
    for (int b = 0; b < nb; b++) begin
      check("read byte", mdl.rb[b], rb_exp(p));
      p = nxt(p);
    end
  endtask : rd
  task automatic act_chk(input logic [9:0] a);
    rd_addr <= a;
    repeat (2) @(posedge mclk);
    check("active", rd_data, act[a]);
  endtask : act_chk
  initial begin
    logic [9:0] a;
    srst = 1'b1;
    rd_addr = '0;
    for (int i = 0; i < 1024; i++) begin
      shadow[i] = 8'h00;
      act[i] = 8'h00;
    end
    shadow[0] = SCP_CFG_RESET;
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    settle();
    rd(2'h0, SCP_CFG_ADDR, 1);
    for (int l = 0; l < 4; l++) begin
      a = 10'h010 + {1'b0, 9'($random(seed))};
      wr(l[1:0], a, l + 1, 0, l == 1 || l == 2, 1'b0);
      rd(l[1:0], a, l + 1);
    end
    wr(2'h0, a, 1, 3, 1'b0, 1'b0);
    rd(2'h0, a, 1);
    wr(2'h1, a, 2, 3, 1'b1, 1'b0);
    rd(2'h1, a, 2);
    act_chk(a);
    mdl.wb[0] = SCP_UPDATE_MASK;
    wr(2'h0, SCP_UPDATE_ADDR, 1, 0, 1'b0, 1'b1);
    for (int n = 0; n < 50 && reg_busy !== 1'b1; n++) @(posedge mclk);
    check("busy", {7'h00, reg_busy}, 8'h01);
    for (int i = 0; i < 1024; i++) act[i] = shadow[i];
    settle();
    act_chk(a);
    act_chk(10'h3ff);
    rd(2'h0, SCP_UPDATE_ADDR, 1);
    mdl.wb[0] = 8'h5c;
    mdl.wb[1] = SCP_CFG_RESET;
    mdl.wb[2] = SCP_BYTE_ZERO;
    wr(2'h3, SCP_ADDR_ONE, 3, 0, 1'b0, 1'b1);
    rd(2'h3, SCP_ADDR_ONE, 3);
    mdl.wb[0] = 8'h5a;
    wr(2'h0, SCP_CFG_ADDR, 1, 0, 1'b0, 1'b1);
    mdl.lsb = 1'b1;
    mdl.wb[0] = 8'($random(seed));
    mdl.wb[1] = 8'($random(seed));
    mdl.wb[2] = SCP_BYTE_ZERO;
    wr(2'h3, 10'h230, 3, 0, 1'b0, 1'b1);
    rd(2'h3, 10'h230, 3);
    mdl.wb[0] = 8'hdb;
    wr(2'h0, SCP_CFG_ADDR, 1, 0, 1'b0, 1'b1);
    mdl.sep = 1'b1;
    rd(2'h0, SCP_CFG_ADDR, 1);
    rd(2'h1, 10'h230, 2);
    mdl.wb[0] = 8'h01;
    wr(2'h0, SCP_RB_SEL_ADDR, 1, 0, 1'b0, 1'b1);
    mdl.wb[0] = SCP_UPDATE_MASK;
    wr(2'h0, SCP_UPDATE_ADDR, 1, 0, 1'b0, 1'b1);
    for (int i = 0; i < 1024; i++) act[i] = shadow[i];
    settle();
    mdl.wb[0] = ~shadow[a];
    wr(2'h0, a, 1, 0, 1'b0, 1'b1);
    rd(2'h0, a, 1);
    act_chk(SCP_RB_SEL_ADDR);
    complete_run();
  end
endmodule : test_serial_control_port_slave

bind scp_slave scp_slave_chk #(.NUM_REGS(NUM_REGS)) u_chk (
  .mclk(mclk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .sdio_o(sdio_o),
  .sdio_oe(sdio_oe), .readback_out_pin(readback_out_pin),
  .readback_out_pin_oe(readback_out_pin_oe),
  .active_rd_addr(active_rd_addr), .active_rd_data(active_rd_data),
  .reg_busy(reg_busy));
